//--- rtl/dpom_dev.sv
// Deserializer parallel output mapper, link clock domain
`timescale 1ns/100ps
`default_nettype none
module dpom_dev import dpom_pkg::*; #(
  parameter int LINK_CLK_KHZ = LINK_CLK_KHZ_DEF
) (
  // Link clock and its reset
  input wire logic link_clk_i,
  input wire logic link_resetn_i,
  // Deserialized word stream
  input wire logic word_valid_i,
  output logic word_ready_o,
  input wire logic [WORD_W-1:0] word_i,
  input wire logic [SYNC_W-1:0] sync_i,
  // Strap pins, asynchronous
  input wire logic local_ctrl_channel_enable_i,
  input wire logic mode_or_sync_decode_pin_i,
  input wire logic double_output_select_i,
  input wire logic error_correction_enable_i,
  input wire logic bus_width_select_i,
  input wire logic latch_edge_select_i,
  input wire logic cable_type_mid_i,
  input wire logic cc_use_i2c_i,
  // Decoded mode status
  output logic control_mode_select_o,
  output logic sync_decode_enable_o,
  output logic error_correction_o,
  output logic cc_full_duplex_o,
  // Register contents
  output logic [7:0] ser_addr_o,
  output logic [7:0] own_addr_o,
  output logic [1:0] gpio_o,
  // Bypass UART, user side
  output logic bypass_rx_o,
  input wire logic bypass_tx_i,
  // Link side
  dpom_link_if.dev lnk
);
  // Halved link clock must sit in the single-mode pixel range
  if (LINK_CLK_KHZ / 2 < SINGLE_MIN_KHZ ||
      LINK_CLK_KHZ / 2 > SINGLE_MAX_KHZ) begin : g_bad_link_clk
    $error("link clock gives a pixel clock out of range");
  end

  // Synchroniser slots
  localparam int NS = 11;
  localparam int S_LCC = 0;
  localparam int S_MS = 1;
  localparam int S_DBL = 2;
  localparam int S_EDC = 3;
  localparam int S_BWS = 4;
  localparam int S_ES = 5;
  localparam int S_MID = 6;
  localparam int S_I2C = 7;
  localparam int S_REQ = 8;
  localparam int S_BYP = 9;
  localparam int S_UTX = 10;

  logic [NS-1:0] s1_reg, s1_next; // First stage, read only by s2
  logic [NS-1:0] s2_reg, s2_next; // Second stage, usable
  logic req_s3_reg, req_s3_next; // Edge detector for the request toggle

  // Decoded straps
  logic lcc_w, base_w, byp_w, sync_decode_enable_w, dbl_w, bws_w, es_w, edc_w;
  logic launch_w;
  logic req_edge_w;

  // Pixel path state
  logic pclk_reg, pclk_next; // Pixel clock, half link rate
  logic half_reg, half_next; // High half pending in double mode
  logic [BUS_W-1:0] hold_reg, hold_next; // Stored upper half
  logic [BUS_W-1:0] bus_reg, bus_next; // Output pins

  // Control channel state
  logic [7:0] ser_addr_reg, ser_addr_next;
  logic [7:0] own_addr_reg, own_addr_next;
  logic [1:0] gpio_reg, gpio_next;
  logic ack_reg, ack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] init_reg, init_next; // Waits out the strap synchroniser
  logic byp_out_reg, byp_out_next;

  // Keep the lowest n bits, clear the rest
  function automatic logic [BUS_W-1:0] keep_low(
    input logic [BUS_W-1:0] v, input int n);
    logic [BUS_W-1:0] m;
    m = '0;
    for (int i = 0; i < BUS_W; i++) begin
      m[i] = (i < n);
    end
    return v & m;
  endfunction

  // Half-word width of the double mapping
  function automatic int half_w(input logic bus_width_select);
    return bus_width_select ? W_HALF_WIDE : W_HALF_NARROW;
  endfunction

  // Synchroniser next values
  always_comb begin
    s1_next = {bypass_tx_i, lnk.cc_bypass_tx, lnk.cc_req_tgl, cc_use_i2c_i,
               cable_type_mid_i, latch_edge_select_i, bus_width_select_i,
               error_correction_enable_i, double_output_select_i,
               mode_or_sync_decode_pin_i, local_ctrl_channel_enable_i};
    s2_next = s1_reg;
    req_s3_next = s2_reg[S_REQ];
  end

  // Synchroniser registers
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      req_s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      req_s3_reg <= req_s3_next;
    end
  end

  // Shared pins change meaning with the channel enable
  assign lcc_w = s2_reg[S_LCC];
  assign base_w = lcc_w & ~s2_reg[S_MS];
  assign byp_w = lcc_w & s2_reg[S_MS];
  assign sync_decode_enable_w = ~lcc_w & s2_reg[S_MS];
  assign edc_w = ~lcc_w & s2_reg[S_EDC];
  assign es_w = ~lcc_w & s2_reg[S_ES];
  assign dbl_w = s2_reg[S_DBL];
  assign bws_w = s2_reg[S_BWS];
  assign req_edge_w = s2_reg[S_REQ] ^ req_s3_reg;

  // Data changes on the edge opposite the latch edge; no launch until the
  // straps have cleared the synchroniser, so the edge cannot flip mid-word
  assign launch_w = (init_reg == INIT_DONE) & (pclk_reg == ~es_w);
  // A new word is taken once per pixel clock, or per two in double
  assign word_ready_o = launch_w & (~dbl_w | ~half_reg);

  // Pixel path next values
  always_comb begin
    int hw;
    logic [WORD_W-1:0] up;
    hw = half_w(bws_w);
    up = word_i >> hw;
    pclk_next = ~pclk_reg;
    half_next = half_reg;
    hold_next = hold_reg;
    bus_next = bus_reg;
    if (launch_w) begin
      if (dbl_w) begin
        if (half_reg) begin
          // Second half, upper bits of the stored word
          bus_next = hold_reg;
          half_next = 1'b0;
        end else if (word_valid_i) begin
          // First half goes out now, upper half waits
          bus_next = keep_low(word_i[BUS_W-1:0], hw);
          hold_next = keep_low(up[BUS_W-1:0], hw);
          half_next = 1'b1;
        end
      end else if (word_valid_i) begin
        // Low 28 or 22 bits of the word each pixel clock, by bus width
        bus_next = keep_low(word_i[BUS_W-1:0],
          bws_w ? W_SINGLE_WIDE : W_SINGLE_NARROW);
        if (sync_decode_enable_w) begin
          bus_next[SYNC_LSB +: SYNC_W] = sync_i;
        end
      end
    end
  end

  // Pixel path registers
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      pclk_reg <= 1'b0;
      half_reg <= 1'b0;
      hold_reg <= '0;
      bus_reg <= '0;
    end else begin
      pclk_reg <= pclk_next;
      half_reg <= half_next;
      hold_reg <= hold_next;
      bus_reg <= bus_next;
    end
  end

  // Control channel next values
  always_comb begin
    ser_addr_next = ser_addr_reg;
    own_addr_next = own_addr_reg;
    gpio_next = gpio_reg;
    ack_next = ack_reg;
    rdata_next = rdata_reg;
    init_next = init_reg;
    // Bypass passes the user UART straight through, idle high otherwise
    byp_out_next = byp_w ? s2_reg[S_UTX] : 1'b1;
    // Strap is caught once its synchroniser has filled
    if (init_reg != INIT_DONE) begin
      init_next = init_reg + 2'h1;
    end
    if (init_reg == INIT_LOAD) begin
      own_addr_next = {s2_reg[S_MID] ? DESID_MID : DESID_STD,
                       1'b0};
    end
    if (req_edge_w) begin
      // Every request is answered, writes outside base mode are dropped
      ack_next = ~ack_reg;
      unique case (lnk.cc_addr)
        REG_SER_ADDR: rdata_next = ser_addr_reg;
        REG_OWN_ADDR: rdata_next = own_addr_reg;
        REG_GPIO: rdata_next = {6'h00, gpio_reg};
        default: rdata_next = 8'h00;
      endcase
      if (lnk.cc_wr && base_w) begin
        unique case (lnk.cc_addr)
          REG_SER_ADDR: ser_addr_next = lnk.cc_wdata;
          REG_OWN_ADDR: own_addr_next = lnk.cc_wdata;
          REG_GPIO: gpio_next = lnk.cc_wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // Control channel registers
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      ser_addr_reg <= SER_ADDR_RST;
      own_addr_reg <= OWN_ADDR_RST;
      gpio_reg <= GPIO_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      init_reg <= 2'h0;
      byp_out_reg <= 1'b1;
    end else begin
      ser_addr_reg <= ser_addr_next;
      own_addr_reg <= own_addr_next;
      gpio_reg <= gpio_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      init_reg <= init_next;
      byp_out_reg <= byp_out_next;
    end
  end

  // Link outputs
  assign lnk.pixel_clock_out = pclk_reg;
  assign lnk.parallel_data_bus = bus_reg;
  assign lnk.cc_ack_tgl = ack_reg;
  assign lnk.cc_rdata = rdata_reg;
  assign lnk.cc_bypass_rx = byp_out_reg;

  // User outputs
  assign control_mode_select_o = byp_w;
  assign sync_decode_enable_o = sync_decode_enable_w;
  assign error_correction_o = edc_w;
  // I2C in base mode shares one line each way, so half duplex
  assign cc_full_duplex_o = lcc_w & ~(base_w & s2_reg[S_I2C]);
  assign ser_addr_o = ser_addr_reg;
  assign own_addr_o = own_addr_reg;
  assign gpio_o = gpio_reg;
  assign bypass_rx_o = byp_w ? s2_reg[S_BYP] : 1'b1;
endmodule // dpom_dev
`default_nettype wire

//--- rtl/dpom_host.sv
// Downstream end: latches pixels and drives the control channel
`timescale 1ns/100ps
`default_nettype none
module dpom_host import dpom_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  // Pixel capture
  input wire logic latch_edge_select_i,
  output logic pix_valid_o,
  output logic [BUS_W-1:0] pix_data_o,
  // Bypass UART, user side
  input wire logic bypass_tx_i,
  output logic bypass_rx_o,
  // Link side
  dpom_link_if.host lnk
);
  // Command states
  typedef enum logic {HS_IDLE, HS_WAIT} dpom_hst_t;

  dpom_hst_t st_reg, st_next;
  logic req_reg, req_next; // Request toggle
  logic wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic rsp_v_reg, rsp_v_next;
  logic [7:0] rsp_d_reg, rsp_d_next;
  logic tx_reg, tx_next;

  // Synchronisers; first stages are read only by second stages
  logic [2:0] pclk_s_reg, pclk_s_next;
  logic [2:0] ack_s_reg, ack_s_next;
  logic [1:0] rx_s_reg, rx_s_next;
  logic [BUS_W-1:0] d1_reg, d1_next, d2_reg, d2_next;
  logic pix_v_reg, pix_v_next;
  logic [BUS_W-1:0] pix_d_reg, pix_d_next;
  logic edge_w;

  // Latch edge seen after synchronising the pixel clock
  assign edge_w = latch_edge_select_i ?
    (pclk_s_reg[2] & ~pclk_s_reg[1]) :
    (~pclk_s_reg[2] & pclk_s_reg[1]);

  // Capture next values
  always_comb begin
    pclk_s_next = {pclk_s_reg[1:0], lnk.pixel_clock_out};
    ack_s_next = {ack_s_reg[1:0], lnk.cc_ack_tgl};
    rx_s_next = {rx_s_reg[0], lnk.cc_bypass_rx};
    d1_next = lnk.parallel_data_bus;
    d2_next = d1_reg;
    pix_v_next = edge_w;
    pix_d_next = edge_w ? d2_reg : pix_d_reg;
  end

  // Capture registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pclk_s_reg <= 3'h0;
      ack_s_reg <= 3'h0;
      rx_s_reg <= 2'h3;
      d1_reg <= '0;
      d2_reg <= '0;
      pix_v_reg <= 1'b0;
      pix_d_reg <= '0;
    end else begin
      pclk_s_reg <= pclk_s_next;
      ack_s_reg <= ack_s_next;
      rx_s_reg <= rx_s_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      pix_v_reg <= pix_v_next;
      pix_d_reg <= pix_d_next;
    end
  end

  // Command next values; one request in flight keeps I2C half duplex
  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rsp_v_next = 1'b0;
    rsp_d_next = rsp_d_reg;
    // UART bypass runs both ways at once
    tx_next = bypass_tx_i;
    unique case (st_reg)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          // Registers are only reachable through this channel
          wr_next = cmd_wr_i;
          addr_next = cmd_addr_i;
          wdata_next = cmd_wdata_i;
          req_next = ~req_reg;
          st_next = HS_WAIT;
        end
      end
      HS_WAIT: begin
        // Read data is settled before the answer toggle arrives
        if (ack_s_reg[2] ^ ack_s_reg[1]) begin
          rsp_v_next = 1'b1;
          rsp_d_next = lnk.cc_rdata;
          st_next = HS_IDLE;
        end
      end
    endcase
  end

  // Command registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= HS_IDLE;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rsp_v_reg <= 1'b0;
      rsp_d_reg <= 8'h00;
      tx_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rsp_v_reg <= rsp_v_next;
      rsp_d_reg <= rsp_d_next;
      tx_reg <= tx_next;
    end
  end

  // Outputs
  assign cmd_ready_o = (st_reg == HS_IDLE);
  assign rsp_valid_o = rsp_v_reg;
  assign rsp_rdata_o = rsp_d_reg;
  assign pix_valid_o = pix_v_reg;
  assign pix_data_o = pix_d_reg;
  assign bypass_rx_o = rx_s_reg[1];
  assign lnk.cc_req_tgl = req_reg;
  assign lnk.cc_wr = wr_reg;
  assign lnk.cc_addr = addr_reg;
  assign lnk.cc_wdata = wdata_reg;
  assign lnk.cc_bypass_tx = tx_reg;
endmodule // dpom_host
`default_nettype wire

//--- rtl/dpom_link_if.sv
// Link between the output mapper and the downstream latching end
`timescale 1ns/100ps
`default_nettype none
interface dpom_link_if import dpom_pkg::*; ();
  // Parallel output and its clock
  logic pixel_clock_out;
  logic [BUS_W-1:0] parallel_data_bus;
  logic lower_half_hsync_out;
  // Control channel request, held while the toggle is pending
  logic cc_req_tgl;
  logic cc_wr;
  logic [7:0] cc_addr;
  logic [7:0] cc_wdata;
  // Control channel answer
  logic cc_ack_tgl;
  logic [7:0] cc_rdata;
  // Bypass UART lines, one each way
  logic cc_bypass_tx;
  logic cc_bypass_rx;
  // Monitoring alias of the lowest sync-capable pin
  assign lower_half_hsync_out = parallel_data_bus[SYNC_LSB];
  modport dev (
    output pixel_clock_out, parallel_data_bus, cc_ack_tgl, cc_rdata,
    output cc_bypass_rx,
    input cc_req_tgl, cc_wr, cc_addr, cc_wdata, cc_bypass_tx
  );
  modport host (
    input pixel_clock_out, parallel_data_bus, cc_ack_tgl, cc_rdata,
    input cc_bypass_rx,
    output cc_req_tgl, cc_wr, cc_addr, cc_wdata, cc_bypass_tx
  );
endinterface // dpom_link_if
`default_nettype wire

//--- rtl/dpom_pkg.sv
// Shared constants for the parallel output mapper and its downstream end
package dpom_pkg;
  // Widths of the output bus and of the deserialized word
  localparam int BUS_W = 28;
  localparam int WORD_W = 30;
  localparam int SYNC_W = 4;
  localparam int SYNC_LSB = 24;
  // Used widths per mapping
  localparam int W_SINGLE_WIDE = 28;
  localparam int W_SINGLE_NARROW = 22;
  localparam int W_HALF_WIDE = 15;
  localparam int W_HALF_NARROW = 11;
  // Control-channel register offsets
  localparam logic [7:0] REG_SER_ADDR = 8'h00;
  localparam logic [7:0] REG_OWN_ADDR = 8'h01;
  localparam logic [7:0] REG_GPIO = 8'h0E;
  // Reset and strap-derived address values
  localparam logic [7:0] SER_ADDR_RST = 8'h80;
  localparam logic [6:0] DESID_STD = 7'h48;
  localparam logic [6:0] DESID_MID = 7'h49;
  localparam logic [7:0] OWN_ADDR_RST = 8'h90;
  localparam logic [1:0] GPIO_RST = 2'h0;
  localparam logic [1:0] INIT_DONE = 2'h3;
  localparam logic [1:0] INIT_LOAD = 2'h2;
  // Pixel clock and serial limits, in kHz and Mbps
  localparam int SINGLE_MIN_KHZ = 6250;
  localparam int SINGLE_MAX_KHZ = 50000;
  localparam int DBL11_MIN_KHZ = 33300;
  localparam int DBL11_MAX_KHZ = 100000;
  localparam int DBL15_MIN_KHZ = 25000;
  localparam int DBL15_MAX_KHZ = 75000;
  localparam int SERIAL_MAX_MBPS = 1500;
  localparam int SINGLE_BITS_AT_MAX = 28;
  // Default link clock, 64 ns period
  localparam int LINK_CLK_KHZ_DEF = 15625;
endpackage

//--- test/dpom_bench.sv
// Self-checking bench: mapper and latching end joined by their link
`timescale 1ns/100ps
`default_nettype none
module dpom_bench import dpom_pkg::*; ;
  // Fixed test word and sync pattern; sync differs from word bits 27:24
  localparam logic [WORD_W-1:0] W = 30'h3A5C_96E7;
  localparam logic [SYNC_W-1:0] S = 4'h5;
  // Clocks, resets and stimulus
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic resetn_i, link_resetn_i, word_valid_i, host_fall, dev_tx, host_tx;
  logic [WORD_W-1:0] word_i;
  logic [SYNC_W-1:0] sync_i;
  // Straps: ctl enable, mode pin, dual, wide, ecc, falling edge, i2c
  logic [6:0] straps;
  logic cmd_valid, cmd_wr, cmd_ready, rsp_valid, pix_valid;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, ser_addr, own_addr;
  logic [BUS_W-1:0] pix_data;
  logic [1:0] gpio;
  logic bypass_mode, sync_on, ecc_on, full_duplex, dev_rx, host_rx;
  logic word_ready, cable_mid;
  int fail_count = 0;
  int n_tests = 0;

  // Unrelated periods keep the two domains drifting against each other
  always #25 clk_i = ~clk_i;
  always #32 link_clk_i = ~link_clk_i;

  dpom_link_if dpom_link_if_i ();
  dpom_dev dpom_dev_i (
    .link_clk_i(link_clk_i), .link_resetn_i(link_resetn_i),
    .word_valid_i(word_valid_i), .word_ready_o(word_ready), .word_i(word_i),
    .sync_i(sync_i), .local_ctrl_channel_enable_i(straps[6]),
    .mode_or_sync_decode_pin_i(straps[5]),
    .double_output_select_i(straps[4]), .bus_width_select_i(straps[3]),
    .error_correction_enable_i(straps[2]),
    .latch_edge_select_i(straps[1]), .cc_use_i2c_i(straps[0]),
    .cable_type_mid_i(cable_mid), .control_mode_select_o(bypass_mode),
    .sync_decode_enable_o(sync_on), .error_correction_o(ecc_on),
    .cc_full_duplex_o(full_duplex), .ser_addr_o(ser_addr),
    .own_addr_o(own_addr), .gpio_o(gpio), .bypass_rx_o(dev_rx),
    .bypass_tx_i(dev_tx), .lnk(dpom_link_if_i));
  dpom_host dpom_host_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_wr_i(cmd_wr), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .latch_edge_select_i(host_fall),
    .pix_valid_o(pix_valid), .pix_data_o(pix_data),
    .bypass_tx_i(host_tx), .bypass_rx_o(host_rx), .lnk(dpom_link_if_i));
  dpom_link_sva dpom_link_sva_i (
    .link_clk_i(link_clk_i), .link_resetn_i(link_resetn_i),
    .clk_i(clk_i), .resetn_i(resetn_i),
    .pixel_clock_out(dpom_link_if_i.pixel_clock_out),
    .parallel_data_bus(dpom_link_if_i.parallel_data_bus),
    .cc_req_tgl(dpom_link_if_i.cc_req_tgl), .cc_wr(dpom_link_if_i.cc_wr),
    .cc_addr(dpom_link_if_i.cc_addr), .cc_wdata(dpom_link_if_i.cc_wdata),
    .cc_ack_tgl(dpom_link_if_i.cc_ack_tgl),
    .cc_rdata(dpom_link_if_i.cc_rdata));

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single place where the run ends
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One control-channel access; waits for the answer pulse
  task automatic reg_op(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cmd_wr <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    do @(negedge clk_i); while (cmd_ready !== 1'b1);
    @(posedge clk_i);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    if (n >= 200) check(32'h1, 32'h0);
    q = rsp_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    reg_op(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    reg_op(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask

  // Straps are synchronised in the device, so allow them to settle
  // Both ends restarted; output straps change only while pclk is held
  task automatic t_restart(input logic [6:0] v);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    link_resetn_i <= 1'b0;
    straps <= v;
    host_fall <= v[1];
    cable_mid <= 1'b1;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge link_clk_i);
    link_resetn_i <= 1'b1;
    repeat (8) @(posedge link_clk_i);
    check(ser_addr, SER_ADDR_RST);
    check(own_addr, {DESID_MID, 1'b0});
  endtask

  task automatic set_straps(input logic [6:0] v);
    @(posedge link_clk_i);
    straps <= v;
    @(posedge clk_i);
    host_fall <= v[1];
    repeat (24) @(posedge link_clk_i);
  endtask

  task automatic pix_get(output logic [BUS_W-1:0] q);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (pix_valid !== 1'b1 && n < 100);
    if (n >= 100) check(32'h1, 32'h0);
    q = pix_data;
  endtask

  // Same word repeats, so captures alternate lo/hi in dual mode
  task automatic t_pixels(input logic [6:0] v, input logic [BUS_W-1:0] lo,
                          input logic [BUS_W-1:0] hi);
    logic [BUS_W-1:0] q;
    int n;
    t_restart(v);
    // One word taken per pixel clock, one per two in double mode
    n = 0;
    repeat (16) begin
      @(negedge link_clk_i);
      n += int'(word_ready);
    end
    check(n, v[4] ? 32'h4 : 32'h8);
    pix_get(q);
    if (q !== lo) pix_get(q);
    check(q, lo);
    pix_get(q);
    check(q, hi);
    pix_get(q);
    check(q, lo);
  endtask

  // Power-up contents and an unmapped read
  task automatic t_defaults();
    rd_chk(REG_SER_ADDR, SER_ADDR_RST);
    rd_chk(REG_OWN_ADDR, {DESID_STD, 1'b0});
    rd_chk(8'h05, 8'h00);
    check(ser_addr, SER_ADDR_RST);
  endtask

  // Base-mode writes land, including the GPIO field
  task automatic t_writes();
    wr(REG_OWN_ADDR, 8'h94);
    wr(REG_SER_ADDR, 8'h82);
    wr(REG_GPIO, 8'hFF);
    rd_chk(REG_OWN_ADDR, 8'h94);
    rd_chk(REG_SER_ADDR, 8'h82);
    rd_chk(REG_GPIO, 8'h03);
    check(own_addr, 8'h94);
    check(gpio, 2'h3);
    check(full_duplex, 1'b1);
  endtask

  // Mode decoding, refused writes and the bypass path both ways
  task automatic t_modes();
    set_straps(7'h41);
    check(full_duplex, 1'b0);
    set_straps(7'h60);
    check(bypass_mode, 1'b1);
    check(full_duplex, 1'b1);
    wr(REG_SER_ADDR, 8'h84);
    rd_chk(REG_SER_ADDR, 8'h82);
    @(posedge clk_i);
    host_tx <= 1'b0;
    @(posedge link_clk_i);
    dev_tx <= 1'b0;
    repeat (12) @(posedge clk_i);
    check(dev_rx, 1'b0);
    check(host_rx, 1'b0);
    host_tx <= 1'b1;
    @(posedge link_clk_i);
    dev_tx <= 1'b1;
    set_straps(7'h24);
    check(sync_on, 1'b1);
    check(ecc_on, 1'b1);
    check(bypass_mode, 1'b0);
    check(host_rx, 1'b1);
    wr(REG_SER_ADDR, 8'h86);
    rd_chk(REG_SER_ADDR, 8'h82);
  endtask

  // Watchdog against a hang
  initial begin
    #1_000_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    resetn_i = 1'b0;
    link_resetn_i = 1'b0;
    word_valid_i = 1'b1;
    word_i = W;
    sync_i = S;
    straps = 7'h40;
    host_fall = 1'b0;
    cable_mid = 1'b0;
    dev_tx = 1'b1;
    host_tx = 1'b1;
    cmd_valid = 1'b0;
    cmd_wr = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge link_clk_i);
    link_resetn_i <= 1'b1;
    repeat (8) @(posedge link_clk_i);
    t_defaults();
    t_writes();
    t_modes();
    t_pixels(7'h08, BUS_W'(W[27:0]), BUS_W'(W[27:0]));
    t_pixels(7'h00, BUS_W'(W[21:0]), BUS_W'(W[21:0]));
    t_pixels(7'h28, {S, W[23:0]}, {S, W[23:0]});
    check(dpom_link_if_i.lower_half_hsync_out, S[0]);
    t_pixels(7'h18, BUS_W'(W[14:0]), BUS_W'(W[29:15]));
    t_pixels(7'h10, BUS_W'(W[10:0]), BUS_W'(W[21:11]));
    t_pixels(7'h0A, BUS_W'(W[27:0]), BUS_W'(W[27:0]));
    give_verdict();
  end
endmodule // dpom_bench
`default_nettype wire

//--- test/dpom_link_sva.sv
// Checker for the link between the output mapper and the latching end
`timescale 1ns/100ps
`default_nettype none
module dpom_link_sva import dpom_pkg::*; (
  // Clocks and resets of both ends
  input wire logic link_clk_i,
  input wire logic link_resetn_i,
  input wire logic clk_i,
  input wire logic resetn_i,
  // Pixel side
  input wire logic pixel_clock_out,
  input wire logic [BUS_W-1:0] parallel_data_bus,
  // Control channel
  input wire logic cc_req_tgl,
  input wire logic cc_wr,
  input wire logic [7:0] cc_addr,
  input wire logic [7:0] cc_wdata,
  input wire logic cc_ack_tgl,
  input wire logic [7:0] cc_rdata
);
  // Output clock is the link clock halved, so it flips on every rising link clock edge
  a_pclk_halves: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $past(link_resetn_i) |-> pixel_clock_out != $past(pixel_clock_out))
    else $error("pixel clock did not toggle");
  // A launched word stands for a whole output clock period
  a_word_holds: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $changed(parallel_data_bus) |=> $stable(parallel_data_bus))
    else $error("output word changed after one link cycle");
  // Request crosses through a synchroniser, so no same-cycle answer
  a_ack_not_early: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $changed(cc_req_tgl) |=> cc_ack_tgl != cc_req_tgl)
    else $error("answer came before the request was synchronised");
  // Every request is answered within a few link cycles
  a_ack_in_time: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $changed(cc_req_tgl) |-> ##[1:8] cc_ack_tgl == cc_req_tgl)
    else $error("request not answered in time");
  // No answer without a pending request
  a_ack_needs_req: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $changed(cc_ack_tgl) |-> $past(cc_req_tgl) != $past(cc_ack_tgl))
    else $error("answer without request");
  // Read data only moves together with an answer
  a_rdata_with_ack: assert property (@(posedge link_clk_i)
    disable iff (!link_resetn_i)
    $changed(cc_rdata) |-> $changed(cc_ack_tgl))
    else $error("read data moved without an answer");
  // Only one request may be outstanding
  a_one_pending: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    $changed(cc_req_tgl) |-> $past(cc_req_tgl) == $past(cc_ack_tgl))
    else $error("new request while one is pending");
  // Request fields stay put until answered
  a_req_held: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    (cc_req_tgl != cc_ack_tgl) && ($past(cc_req_tgl) != $past(cc_ack_tgl))
    |-> $stable(cc_addr) && $stable(cc_wr) && $stable(cc_wdata))
    else $error("request fields changed while pending");
endmodule // dpom_link_sva
`default_nettype wire
